/* File: hw/afe_serial_config_port.sv */
// Serial configuration port with readback unlock and analog control outputs
`timescale 1ns/100ps
`include "afe_serial_config_map.svh"
module afe_serial_config_port
(
  // System clock and reset
  input  wire logic                              mclk,
  input  wire logic                              nrst,
  // Serial link
  input  wire logic                              sclk,
  input  wire logic                              chip_select_n,
  input  wire logic                              sdio_in,
  output logic                                   sdio_out,
  output logic                                   sdio_oe_n,
  // Configuration to the analog section
  output afe_serial_config_pkg::config_type      device_config,
  output logic [7:0]                             offset_dac_code,
  output afe_serial_config_pkg::analog_type      analog_setting,
  // Status
  output logic                                   readback_mode,
  output logic                                   write_pulse
);
  import afe_serial_config_pkg::*;

  // Link domain: framing
  logic                 frame_rst_n;
  logic [3:0]           bit_cnt;
  logic [6:0]           shift_in;
  logic [7:0]           instr;
  logic [3:0]           next_bit_cnt;
  logic [6:0]           next_shift_in;
  logic [7:0]           next_instr;

  // Link domain: register mirror and unlock state
  logic [7:0]           mirror_config;
  logic [7:0]           mirror_dac;
  unlock_type           unlock_state;
  write_type            commit_word;
  logic                 commit_toggle;
  logic [7:0]           next_mirror_config;
  logic [7:0]           next_mirror_dac;
  unlock_type           next_unlock_state;
  write_type            next_commit_word;
  logic                 next_commit_toggle;
  logic [7:0]           data_byte;
  logic                 instr_ok;
  logic                 addr_ok;
  logic                 commit_now;

  // Link domain: read data, on falling edges
  logic [7:0]           out_shift;
  logic                 drive;
  logic [7:0]           next_out_shift;
  logic                 next_drive;
  logic [7:0]           read_data;
  logic                 read_ok;

  // System domain
  logic                 write_event;
  logic                 unlocked_level;
  config_type           next_device_config;
  logic [7:0]           next_offset_dac_code;
  analog_type           next_analog_setting;
  logic                 next_write_pulse;

  // Framing restarts whenever select is high
  assign frame_rst_n = nrst & ~chip_select_n;

  always_comb
  begin
    next_bit_cnt  = 4'(bit_cnt + `CNT_STEP);
    next_shift_in = {shift_in[5:0], sdio_in};
    next_instr    = instr;
    if (bit_cnt == `CNT_INSTR_LAST)
    begin
      next_instr = {shift_in, sdio_in};
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt  <= 4'h0;
      shift_in <= 7'h00;
      instr    <= 8'h00;
    end
    else
    begin
      bit_cnt  <= next_bit_cnt;
      shift_in <= next_shift_in;
      instr    <= next_instr;
    end
  end

  assign data_byte = {shift_in, sdio_in};
  // Reserved field must be zero and the address mapped
  assign instr_ok  = (instr[`RSVD_HI:`RSVD_LO] == `RSVD_ZERO);
  assign addr_ok   = (instr[`ADDR_HI:0] == `ADDR_CONFIG) ||
                     (instr[`ADDR_HI:0] == `ADDR_DAC) ||
                     (instr[`ADDR_HI:0] == `ADDR_MODE);
  assign commit_now = (bit_cnt == `CNT_DATA_LAST) && !instr[`DIR_BIT] &&
                      instr_ok && addr_ok;

  always_comb
  begin
    next_mirror_config = mirror_config;
    next_mirror_dac    = mirror_dac;
    next_unlock_state  = unlock_state;
    next_commit_word   = commit_word;
    next_commit_toggle = commit_toggle;
    if (commit_now)
    begin
      next_commit_word.addr = instr[`ADDR_HI:0];
      next_commit_word.data = data_byte;
      next_commit_toggle    = ~commit_toggle;
      if (instr[`ADDR_HI:0] == `ADDR_CONFIG)
      begin
        next_mirror_config = data_byte;
      end
      else if (instr[`ADDR_HI:0] == `ADDR_DAC)
      begin
        next_mirror_dac = data_byte;
      end
      else
      begin
        case (unlock_state)
          ARMED:
          begin
            if (data_byte == `UNLOCK_SECOND)
            begin
              next_unlock_state = UNLOCKED;
            end
            else if (data_byte == `UNLOCK_FIRST)
            begin
              next_unlock_state = ARMED;
            end
            else
            begin
              next_unlock_state = LOCKED;
            end
          end
          default:
          begin
            if (data_byte == `UNLOCK_FIRST)
            begin
              next_unlock_state = ARMED;
            end
            else
            begin
              next_unlock_state = LOCKED;
            end
          end
        endcase
      end
    end
  end

  // Mirror survives select; only the system reset clears it
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mirror_config <= `RESET_CONFIG;
      mirror_dac    <= `RESET_DAC;
      unlock_state  <= LOCKED;
      commit_word   <= '0;
      commit_toggle <= 1'b0;
    end
    else
    begin
      mirror_config <= next_mirror_config;
      mirror_dac    <= next_mirror_dac;
      unlock_state  <= next_unlock_state;
      commit_word   <= next_commit_word;
      commit_toggle <= next_commit_toggle;
    end
  end

  // Read data selection; the unlock register is write-only
  always_comb
  begin
    read_data = 8'h00;
    if (instr[`ADDR_HI:0] == `ADDR_CONFIG)
    begin
      read_data = mirror_config;
    end
    else if (instr[`ADDR_HI:0] == `ADDR_DAC)
    begin
      read_data = mirror_dac;
    end
  end

  assign read_ok = instr[`DIR_BIT] && instr_ok && (unlock_state == UNLOCKED) &&
                   ((instr[`ADDR_HI:0] == `ADDR_CONFIG) ||
                    (instr[`ADDR_HI:0] == `ADDR_DAC));

  always_comb
  begin
    next_out_shift = out_shift;
    next_drive     = 1'b0;
    if (bit_cnt == `CNT_DATA_FIRST)
    begin
      next_out_shift = read_data;
      next_drive     = read_ok;
    end
    else if (bit_cnt[`CNT_DATA_BIT] && drive)
    begin
      next_out_shift = {out_shift[6:0], 1'b0};
      next_drive     = 1'b1;
    end
  end

  // Read data changes on falling edges so the master samples on rising ones
  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      out_shift <= 8'h00;
      drive     <= 1'b0;
    end
    else
    begin
      out_shift <= next_out_shift;
      drive     <= next_drive;
    end
  end

  assign sdio_out  = out_shift[7];
  // Released at the sixteenth rising edge when the count wraps
  assign sdio_oe_n = ~(drive & bit_cnt[`CNT_DATA_BIT]);

  // Crossing into the system clock
  event_sync u_write_sync
  (
    .mclk      (mclk),
    .nrst      (nrst),
    .toggle_in (commit_toggle),
    .pulse_out (write_event)
  );

  level_sync u_mode_sync
  (
    .mclk      (mclk),
    .nrst      (nrst),
    .level_in  (unlock_state == UNLOCKED),
    .level_out (unlocked_level)
  );

  always_comb
  begin
    next_device_config   = device_config;
    next_offset_dac_code = offset_dac_code;
    next_write_pulse     = write_event;
    if (write_event)
    begin
      if (commit_word.addr == `ADDR_CONFIG)
      begin
        next_device_config = config_type'(commit_word.data);
      end
      else if (commit_word.addr == `ADDR_DAC)
      begin
        next_offset_dac_code = commit_word.data;
      end
    end
    if (next_device_config.first_stage_gain_sel)
    begin
      next_analog_setting.first_stage_gain = `FIRST_STAGE_GAIN_SEL_HIGH_SEL;
    end
    else
    begin
      next_analog_setting.first_stage_gain = `FIRST_STAGE_GAIN_SEL_LOW_SEL;
    end
    case (next_device_config.second_stage_gain_sel)
      2'h0:
      begin
        next_analog_setting.second_stage_gain = `SECOND_STAGE_GAIN_SEL_X4;
      end
      2'h1:
      begin
        next_analog_setting.second_stage_gain = `SECOND_STAGE_GAIN_SEL_X8;
      end
      2'h2:
      begin
        next_analog_setting.second_stage_gain = `SECOND_STAGE_GAIN_SEL_X16;
      end
      default:
      begin
        next_analog_setting.second_stage_gain = `SECOND_STAGE_GAIN_SEL_X32;
      end
    endcase
    if (next_device_config.bias_level_sel)
    begin
      next_analog_setting.bias_voltage = `BIAS_HIGH_MV;
    end
    else
    begin
      next_analog_setting.bias_voltage = `BIAS_LOW_MV;
    end
  end

  // external_filter_route drives the filter switch directly
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      device_config   <= config_type'(`RESET_CONFIG);
      offset_dac_code <= `RESET_DAC;
      analog_setting  <= {`FIRST_STAGE_GAIN_SEL_LOW_SEL, `SECOND_STAGE_GAIN_SEL_X4, `BIAS_LOW_MV};
      write_pulse     <= 1'b0;
      readback_mode   <= 1'b0;
    end
    else
    begin
      device_config   <= next_device_config;
      offset_dac_code <= next_offset_dac_code;
      analog_setting  <= next_analog_setting;
      write_pulse     <= next_write_pulse;
      readback_mode   <= unlocked_level;
    end
  end

endmodule : afe_serial_config_port

/* File: pkg/afe_serial_config_map.svh */
// Constants of the serial configuration port
// Function
// - Select release abandons unfinished transaction
// - Select assertion restarts serial framing
// - Select tied low frames by edge count
// - Write is instruction byte then data byte
// - Reads drive nothing until unlocked
// - Unlocked reads drive register data
// - Readback persists until other mode write
// - Instruction bit 7 gives direction
// - Bits 3:0 address byte-wide registers
// - First gain select: 250 clear, 42 set
// - Second gain field selects 4,8,16,32
// - Filter route bit sends via external filter
// - Bias select: 1.15V clear, 2.59V set
// - Unlock by 0xFE then 0xED writes
// - Map: config 0x0, DAC 0x1, unlock 0xF
// - Configuration register bit layout
// - Sample rising, drive from ninth fall
`ifndef AFE_SERIAL_CONFIG_MAP_SVH
`define AFE_SERIAL_CONFIG_MAP_SVH

`define ADDR_CONFIG      4'h0
`define ADDR_DAC         4'h1
`define ADDR_MODE        4'hF
`define RESET_CONFIG     8'h00
`define RESET_DAC        8'h80
`define UNLOCK_FIRST     8'hFE
`define UNLOCK_SECOND    8'hED
`define DIR_BIT          7
`define RSVD_HI          6
`define RSVD_LO          4
`define ADDR_HI          3
`define CNT_INSTR_LAST   4'h7
`define CNT_DATA_FIRST   4'h8
`define CNT_DATA_LAST    4'hF
`define CNT_STEP         4'h1
`define CNT_DATA_BIT     3
`define RSVD_ZERO        3'h0
`define FIRST_STAGE_GAIN_SEL_LOW_SEL    8'hFA
`define FIRST_STAGE_GAIN_SEL_HIGH_SEL   8'h2A
`define SECOND_STAGE_GAIN_SEL_X4         6'h04
`define SECOND_STAGE_GAIN_SEL_X8         6'h08
`define SECOND_STAGE_GAIN_SEL_X16        6'h10
`define SECOND_STAGE_GAIN_SEL_X32        6'h20
`define BIAS_LOW_MV      12'h47E
`define BIAS_HIGH_MV     12'hA1E

`endif

/* File: pkg/afe_serial_config_pkg.sv */
// Types of the serial configuration port
package afe_serial_config_pkg;

  typedef struct packed {
    logic       input_channel_sel;
    logic [1:0] amp_enable;
    logic       external_filter_route;
    logic       bias_level_sel;
    logic [1:0] second_stage_gain_sel;
    logic       first_stage_gain_sel;
  } config_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } write_type;

  typedef struct packed {
    logic [7:0]  first_stage_gain;
    logic [5:0]  second_stage_gain;
    logic [11:0] bias_voltage;
  } analog_type;

  typedef enum logic [2:0] {
    LOCKED   = 3'h1,
    ARMED    = 3'h2,
    UNLOCKED = 3'h4
  } unlock_type;

endpackage : afe_serial_config_pkg

/* File: hw/level_sync.sv */
// Two-flop synchroniser for one level
`timescale 1ns/100ps
module level_sync
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Level in and out
  input  wire logic level_in,
  output logic      level_out
);

  logic stage1;
  logic next_stage1;
  logic next_level_out;

  always_comb
  begin
    next_stage1    = level_in;
    next_level_out = stage1;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1    <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      stage1    <= next_stage1;
      level_out <= next_level_out;
    end
  end

endmodule : level_sync

/* File: hw/event_sync.sv */
// Toggle crossing that turns a toggle into a one-cycle pulse
`timescale 1ns/100ps
module event_sync
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Toggle in, pulse out
  input  wire logic toggle_in,
  output logic      pulse_out
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_stage1;
  logic next_stage2;
  logic next_stage3;

  always_comb
  begin
    next_stage1 = toggle_in;
    next_stage2 = stage1;
    next_stage3 = stage2;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
    end
  end

  assign pulse_out = stage2 ^ stage3;

endmodule : event_sync

/* File: verification/afe_serial_config_port_properties.sv */
// Port assertions of the serial configuration port
`timescale 1ns/100ps
module afe_serial_config_port_properties
  import afe_serial_config_pkg::*;
(
  // System clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // Serial link
  input wire logic       sclk,
  input wire logic       chip_select_n,
  input wire logic       sdio_in,
  input wire logic       sdio_out,
  input wire logic       sdio_oe_n,
  // Configuration and status
  input wire config_type device_config,
  input wire logic [7:0] offset_dac_code,
  input wire analog_type analog_setting,
  input wire logic       readback_mode,
  input wire logic       write_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_reset_values: assert property ($rose(nrst) |->
    device_config == 8'h00 && offset_dac_code == 8'h80)
    else $error("register value after reset is wrong");
  a_change_on_pulse: assert property (
    $changed(device_config) || $changed(offset_dac_code) |-> write_pulse)
    else $error("register changed without a write pulse");
  a_pulse_single: assert property (write_pulse |=> !write_pulse)
    else $error("write pulse longer than one cycle");
  a_first_stage_gain_sel_decode: assert property (analog_setting.first_stage_gain ==
    (device_config.first_stage_gain_sel ? 8'h2A : 8'hFA))
    else $error("first stage gain decode wrong");
  a_second_stage_gain_sel_decode: assert property (analog_setting.second_stage_gain ==
    (6'h04 << device_config.second_stage_gain_sel))
    else $error("second stage gain decode wrong");
  a_bias_decode: assert property (analog_setting.bias_voltage ==
    (device_config.bias_level_sel ? 12'hA1E : 12'h47E))
    else $error("bias voltage decode wrong");
  a_select_idle: assert property (chip_select_n |-> sdio_oe_n)
    else $error("data line driven while deselected");
  a_locked_quiet: assert property (!readback_mode |-> sdio_oe_n)
    else $error("data line driven while readback locked");
  a_drive_span: assert property ($fell(sdio_oe_n) |-> !sdio_oe_n [*8])
    else $error("read drive ended too early");
endmodule : afe_serial_config_port_properties

bind afe_serial_config_port afe_serial_config_port_properties props
(
  .mclk(mclk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n),
  .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
  .device_config(device_config), .offset_dac_code(offset_dac_code),
  .analog_setting(analog_setting), .readback_mode(readback_mode),
  .write_pulse(write_pulse)
);

/* File: verification/spi_master_model.sv */
// Serial master model that frames transactions on the configuration link
`timescale 1ns/100ps
module spi_master_model
(
  // Serial link
  output logic      sclk,
  output logic      chip_select_n,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n
);
  logic       drive_en;
  logic       drive_bit;
  logic [7:0] rd_byte;
  logic       seen_drive;

  // Released line shows the master bit, or its inverse once the master stops driving, never a held value
  assign sdio_in = !sdio_oe_n ? sdio_out : (drive_en ? drive_bit : !drive_bit);

  initial
  begin
    sclk = 1'b1;
    chip_select_n = 1'b1;
    drive_en = 1'b1;
    drive_bit = 1'b0;
    rd_byte = 8'h00;
    seen_drive = 1'b0;
  end

  always @(negedge sdio_oe_n) seen_drive = 1'b1;

  // Sends n bits of word at a 32 ns period; fewer than 16 with keep_low clear aborts the frame
  task xfer(input logic [15:0] word, input int n, input bit keep_low);
    int i;
    seen_drive = 1'b0;
    chip_select_n = 1'b0;
    #16;
    for (i = 0; i < n; i++)
    begin
      sclk = 1'b0;
      drive_en = !(word[15] && i > 7);
      drive_bit = word[15 - i];
      #16;
      // Take the device bit while it is settled, before the rise moves its counter
      if (i > 7) rd_byte = {rd_byte[6:0], sdio_in};
      sclk = 1'b1;
      #16;
    end
    drive_en = 1'b1;
    if (!keep_low) chip_select_n = 1'b1;
    #48;
  endtask : xfer
endmodule : spi_master_model

/* File: verification/afe_serial_config_port_test.sv */
// Self-checking bench of the serial configuration port
`timescale 1ns/100ps
module afe_serial_config_port_test;
  import afe_serial_config_pkg::*;
  logic       mclk;
  logic       nrst;
  logic       sclk;
  logic       chip_select_n;
  logic       sdio_in;
  logic       sdio_out;
  logic       sdio_oe_n;
  config_type device_config;
  logic [7:0] offset_dac_code;
  analog_type analog_setting;
  logic       readback_mode;
  logic       write_pulse;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;
  logic [7:0] cfg_table [4] = '{8'hFF, 8'hA4, 8'h00, 8'h5B};
  logic [7:0] rd_table [3] = '{8'h5B, 8'h3C, 8'h5B};

  afe_serial_config_port dut
  (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .device_config(device_config), .offset_dac_code(offset_dac_code),
    .analog_setting(analog_setting), .readback_mode(readback_mode),
    .write_pulse(write_pulse)
  );

  spi_master_model master
  (
    .sclk(sclk), .chip_select_n(chip_select_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n)
  );

  function automatic analog_type exp_analog(input logic [7:0] v);
    exp_analog.first_stage_gain = v[0] ? 8'h2A : 8'hFA;
    exp_analog.second_stage_gain = 6'h04 << v[2:1];
    exp_analog.bias_voltage = v[3] ? 12'hA1E : 12'h47E;
  endfunction : exp_analog

  task check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task check_analog(input string what, input analog_type exp, input analog_type got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_analog

  // One frame, then time for the crossing to land
  task send(input logic [15:0] word, input int n, input bit keep_low);
    @(posedge mclk);
    #1;
    master.xfer(word, n, keep_low);
    repeat (10) @(posedge mclk);
    #1;
  endtask : send

  task conclude;
    $display("total_checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude;
    end
  end

  initial
  begin
    nrst = 1'b0;
    repeat (5) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_byte("device_config", 8'h00, device_config);
    check_byte("offset_dac_code", 8'h80, offset_dac_code);
    check_analog("analog_setting", exp_analog(8'h00), analog_setting);
    foreach (cfg_table[k])
    begin
      send({8'h00, cfg_table[k]}, 16, 1'b0);
      check_byte("device_config", cfg_table[k], device_config);
      check_analog("analog_setting", exp_analog(cfg_table[k]), analog_setting);
    end
    send({8'h00, 8'h77}, 12, 1'b0);
    send({8'h01, 8'h3C}, 16, 1'b0);
    check_byte("offset_dac_code", 8'h3C, offset_dac_code);
    send({8'h10, 8'h77}, 16, 1'b0);
    send({8'h05, 8'h77}, 16, 1'b0);
    check_byte("device_config", 8'h5B, device_config);
    check_byte("offset_dac_code", 8'h3C, offset_dac_code);
    send({8'h80, 8'h00}, 16, 1'b0);
    check_byte("locked read drive", 8'h00, {7'h00, master.seen_drive});
    send({8'h0F, 8'hFE}, 16, 1'b0);
    send({8'h0F, 8'hED}, 16, 1'b0);
    check_byte("readback_mode", 8'h01, {7'h00, readback_mode});
    foreach (rd_table[k])
    begin
      send({7'h40, k == 1, 8'h00}, 16, 1'b0);
      check_byte("read data", rd_table[k], master.rd_byte);
      check_byte("read drive", 8'h01, {7'h00, master.seen_drive});
    end
    send({8'h8F, 8'h00}, 16, 1'b0);
    check_byte("unlock read drive", 8'h00, {7'h00, master.seen_drive});
    send({8'h0F, 8'h00}, 16, 1'b0);
    check_byte("readback_mode", 8'h00, {7'h00, readback_mode});
    send({8'h01, 8'h11}, 16, 1'b1);
    send({8'h00, 8'h22}, 16, 1'b1);
    check_byte("offset_dac_code", 8'h11, offset_dac_code);
    check_byte("device_config", 8'h22, device_config);
    conclude;
  end
endmodule : afe_serial_config_port_test
